// *** hdl/tbc_core.sv ***
// PWM time base sync select, event postscaler and input clock divider.
`timescale 1ns/1ps
// Contract
// (R1) Source 000 pin, 010/011 trigger 16/17.
// (R2) Trigger once every n+1 compare matches.
// (R3) Divide clock by 2^k; 111 reserved.
// (R4) Software changes settings only while disabled.
// (R5) Software sets period above external sync period.
// (R6) Divider register bits 15-3 read zero.
// (R7) Clear postscale counter while disabled.
module tbc_core
    import tbc_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    input  wire tbc_wb_req_t wb_req_in,
    output logic             wb_ack_out,
    output logic [31:0]      wb_dat_out,
    input  wire logic        external_sync_in,
    input  wire logic        trigger_gen_output_16_in,
    input  wire logic        trigger_gen_output_17_in,
    input  wire logic        compare_match_in,
    output logic             sync_out,
    output logic             special_event_out,
    output logic             clock_enable_out,
    output logic             time_base_enable_out
);
    tbc_ctrl_t   ctrl_r;
    logic [2:0]  div_r;
    logic [3:0]  ps_cnt_r;
    logic [5:0]  div_cnt_r;
    logic        pin_meta_r;
    logic        pin_sync_r;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic        sync_r;
    logic        sev_r;
    logic        ce_r;

    wire         bus_hit   = wb_req_in.cyc && wb_req_in.stb && !ack_r;
    wire         wr_low    = bus_hit && wb_req_in.we && wb_req_in.sel[0];
    wire         wr_high   = bus_hit && wb_req_in.we && wb_req_in.sel[1];
    wire [1:0]   word_idx  = wb_req_in.adr[3:2];
    wire         sel_ctrl  = (word_idx == TBC_ADR_CTRL);
    wire         sel_div   = (word_idx == TBC_ADR_DIV);
    wire         sel_stat  = (word_idx == TBC_ADR_STAT);
    wire [2:0]   new_src   = wb_req_in.dat[TBC_SRC_LSB +: 3];
    wire [3:0]   new_ps    = wb_req_in.dat[TBC_PS_LSB +: 4];
    wire [2:0]   new_div   = wb_req_in.dat[TBC_DIV_LSB +: 3];

    // Reserved source codes select nothing.
    wire sync_sel =
        (ctrl_r.src == TBC_SRC_PIN)   ? pin_sync_r :
        (ctrl_r.src == TBC_SRC_TRG16) ? trigger_gen_output_16_in :
        (ctrl_r.src == TBC_SRC_TRG17) ? trigger_gen_output_17_in : 1'b0; // [R1]

    wire ps_done = (ps_cnt_r == ctrl_r.ps); // [R2]
    // Reserved divider code 111 holds the enable low.
    wire [5:0] div_top = 6'((7'h1 << div_r) - 7'h1); // [R3]
    wire div_tick = (div_r != TBC_DIV_RESERVED) && (div_cnt_r == div_top);

    wire [31:0] ctrl_word = {16'h0, ctrl_r.enable, 8'h0, ctrl_r.src, ctrl_r.ps};
    wire [31:0] div_word  = {29'h0, div_r}; // [R6]
    wire [31:0] stat_word = {24'h0, ps_cnt_r, 1'b0, sync_r, sev_r, ce_r};
    // Unmapped words read as zero, and a write to them changes nothing.
    wire [31:0] rd_mux =
        sel_ctrl ? ctrl_word : sel_div ? div_word : sel_stat ? stat_word : 32'h0;

    // Two flip-flops bring the external sync pin into the clock domain.
    always_ff @(posedge sys_clk_in)
    begin
        pin_meta_r <= external_sync_in;
        pin_sync_r <= pin_meta_r;
    end

    // Ack is a one-cycle pulse, so a strobe held over it is not taken twice.
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0;
        end
        else
        begin
            ack_r  <= bus_hit;
            rdat_r <= bus_hit ? rd_mux : 32'h0;
        end
    end

    // Settings writes are accepted at any time; software keeps them to disabled periods.
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_r <= '{enable: 1'b0, src: TBC_SRC_PIN, ps: TBC_PS_RESET};
            div_r  <= TBC_DIV_RESET;
        end
        else
        begin
            if (sel_ctrl && wr_low)
            begin
                ctrl_r.src <= new_src; // [R4]
                ctrl_r.ps  <= new_ps;
            end
            if (sel_ctrl && wr_high)
                ctrl_r.enable <= wb_req_in.dat[TBC_ENABLE_BIT];
            if (sel_div && wr_low)
                div_r <= new_div; // [R6]
        end
    end

    // The postscale count restarts at each enable, so the first trigger gets its full count.
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in || !ctrl_r.enable)
            ps_cnt_r <= TBC_PS_RESET; // [R7]
        else if (compare_match_in)
            ps_cnt_r <= ps_done ? TBC_PS_RESET : 4'(ps_cnt_r + 4'h1); // [R2]
    end

    // The divider counter runs only while enabled, and its tick becomes the clock enable.
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in || !ctrl_r.enable || div_tick)
            div_cnt_r <= 6'h0;
        else
            div_cnt_r <= 6'(div_cnt_r + 6'h1); // [R3]
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            sync_r <= 1'b0;
            sev_r  <= 1'b0;
            ce_r   <= 1'b0;
        end
        else
        begin
            sync_r <= ctrl_r.enable && sync_sel; // [R1] [R5]
            sev_r  <= ctrl_r.enable && compare_match_in && ps_done; // [R2]
            ce_r   <= ctrl_r.enable && div_tick; // [R3]
        end
    end

    // Every output comes straight from a flip-flop.
    assign wb_ack_out           = ack_r;
    assign wb_dat_out           = rdat_r;
    assign sync_out             = sync_r;
    assign special_event_out    = sev_r;
    assign clock_enable_out     = ce_r;
    assign time_base_enable_out = ctrl_r.enable;

    chk_source_pin: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R1]
        ctrl_r.enable && ctrl_r.src == TBC_SRC_PIN && $stable(ctrl_r)
        |=> sync_out == $past(pin_sync_r))
        else $error("Sync output does not follow the external pin.");
    chk_source_trg17: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R1]
        ctrl_r.enable && ctrl_r.src == TBC_SRC_TRG17
        |=> sync_out == $past(trigger_gen_output_17_in))
        else $error("Sync output does not follow trigger 17.");
    chk_source_reserved: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R1]
        ctrl_r.src[2] || ctrl_r.src == 3'h1 |=> !sync_out)
        else $error("Reserved source drives sync.");
    chk_event_every: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R2]
        special_event_out |-> $past(compare_match_in) && $past(ps_cnt_r) == $past(ctrl_r.ps))
        else $error("Event trigger without its final compare match.");
    chk_event_one_one: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R2]
        ctrl_r.enable && ctrl_r.ps == 4'h0 && compare_match_in |=> special_event_out)
        else $error("Postscale 1:1 missed an event.");
    chk_divide_one: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R3]
        ctrl_r.enable && div_r == 3'h0 ##1 ctrl_r.enable && div_r == 3'h0
        |=> clock_enable_out)
        else $error("Divide-by-1 did not enable every cycle.");
    chk_divide_two: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R3]
        clock_enable_out && div_r == 3'h1 && $stable(div_r) && ctrl_r.enable
        ##1 ctrl_r.enable && div_r == 3'h1
        |-> !clock_enable_out ##1 clock_enable_out)
        else $error("Divide-by-2 spacing wrong.");
    chk_divide_reserved: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R3]
        div_r == TBC_DIV_RESERVED |=> !clock_enable_out)
        else $error("Reserved divider code produced an enable.");
    chk_div_read_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R6]
        wb_ack_out && $past(sel_div) |-> wb_dat_out[31:3] == 29'h0)
        else $error("Divider upper bits not zero.");
    chk_counter_cleared: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R7]
        !ctrl_r.enable |=> ps_cnt_r == 4'h0)
        else $error("Postscale counter not cleared while disabled.");
    chk_bus_ack_drop: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        wb_ack_out |=> !wb_ack_out)
        else $error("Ack held two cycles.");

    // Trigger 16 drives sync; sync, event and clock outputs stay quiet while disabled; the divider code lands as written.
    chk_source_trg16: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R1]
        ctrl_r.enable && ctrl_r.src == TBC_SRC_TRG16
        |=> sync_out == $past(trigger_gen_output_16_in))
        else $error("Sync output does not follow trigger 16.");
    chk_sync_disabled: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R1]
        !ctrl_r.enable |=> !sync_out)
        else $error("Sync output active while disabled.");
    chk_event_disabled: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R2]
        !ctrl_r.enable |=> !special_event_out)
        else $error("Event trigger while disabled.");
    chk_clock_disabled: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R3]
        !ctrl_r.enable |=> !clock_enable_out)
        else $error("Clock enable while disabled.");
    chk_div_stored: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // [R6]
        sel_div && wr_low |=> div_r == $past(new_div))
        else $error("Divider code not stored.");
    chk_bus_answer: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        bus_hit |=> wb_ack_out)
        else $error("Bus request not answered.");
    chk_read_idle: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("Read data not zero outside ack.");

    cov_event_sixteen: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ctrl_r.ps == 4'hf && special_event_out);
    cov_divide_64: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        div_r == 3'h6 && clock_enable_out);
    cov_trg16_sync: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ctrl_r.src == TBC_SRC_TRG16 && sync_out);
    cov_pin_sync: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ctrl_r.enable && ctrl_r.src == TBC_SRC_PIN && sync_out);
    cov_divide_one: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ctrl_r.enable && div_r == TBC_DIV_RESET && clock_enable_out);
endmodule

// *** hdl/tbc_pkg.sv ***
// Package for the PWM time base sync and clock control block.
package tbc_pkg;
    localparam logic [1:0]  TBC_ADR_CTRL     = 2'h0;
    localparam logic [1:0]  TBC_ADR_DIV      = 2'h1;
    localparam logic [1:0]  TBC_ADR_STAT     = 2'h2;
    localparam int          TBC_ENABLE_BIT   = 15;
    localparam int          TBC_SRC_LSB      = 4;
    localparam int          TBC_PS_LSB       = 0;
    localparam int          TBC_DIV_LSB      = 0;
    localparam logic [2:0]  TBC_SRC_PIN      = 3'h0;
    localparam logic [2:0]  TBC_SRC_TRG16    = 3'h2;
    localparam logic [2:0]  TBC_SRC_TRG17    = 3'h3;
    localparam logic [2:0]  TBC_DIV_RESERVED = 3'h7;
    localparam logic [2:0]  TBC_DIV_RESET    = 3'h0;
    localparam logic [3:0]  TBC_PS_RESET     = 4'h0;

    typedef struct packed {
        logic       enable;
        logic [2:0] src;
        logic [3:0] ps;
    } tbc_ctrl_t;

    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } tbc_wb_req_t;
endpackage

// *** tb/tb.sv ***
// Self-checking bench for the PWM time base control block.
`timescale 1ns/1ps
module tb
    import tbc_pkg::*;
;
    localparam logic [2:0] PAT [3] = '{3'h5, 3'h2, 3'h6};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    tbc_wb_req_t req = '0;
    logic        ext = 1'b0, t16 = 1'b0, t17 = 1'b0, cm = 1'b0;
    logic        ack, so, ev, ce, en;
    logic [31:0] rd;
    logic [31:0] expq [$];
    logic [3:0]  p;
    int          n_mismatch = 0, comparisons = 0, cyc_n = 0, n_ev = 0, n, seed = 24;

    always #10 clk = ~clk;

    tbc_core i_tbc_core (.sys_clk_in(clk), .reset_n_in(rst_n), .wb_req_in(req),
        .wb_ack_out(ack), .wb_dat_out(rd), .external_sync_in(ext), .compare_match_in(cm),
        .trigger_gen_output_16_in(t16), .trigger_gen_output_17_in(t17), .sync_out(so),
        .special_event_out(ev), .clock_enable_out(ce), .time_base_enable_out(en));

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, 4'hf, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        req <= '0;
    endtask

    // Notes the expected read data for the monitor, then reads.
    task rdx(input logic [3:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task match(input int k);
        repeat (k)
        begin
            @(posedge clk);
            cm <= 1'b1;
            @(posedge clk);
            cm <= 1'b0;
            repeat ($unsigned($random(seed)) % 3) @(posedge clk);
        end
    endtask

    function automatic logic [31:0] cw(logic e, logic [2:0] s, logic [3:0] q);
        return (32'(e) << TBC_ENABLE_BIT) | (32'(s) << TBC_SRC_LSB) | (32'(q) << TBC_PS_LSB);
    endfunction

    // Compares read data at each read ack and cuts a hang short.
    always @(posedge clk)
    begin
        cyc_n++;
        if (ev === 1'b1)
            n_ev++;
        if (ack === 1'b1 && req.cyc && !req.we && expq.size() > 0)
            check(rd, expq.pop_front());
        if (cyc_n == 20000)
        begin
            n_mismatch++;
            report_and_stop;
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdx(4'h0, cw(1'b0, TBC_SRC_PIN, TBC_PS_RESET));
        rdx(4'h4, {29'h0, TBC_DIV_RESET});
        rdx(4'hc, 32'h0);
        bus(1'b1, 4'h4, 32'hffff_fffe);
        rdx(4'h4, 32'h6);
        $display("test registers done");
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, 4'h4, 32'(k));
            bus(1'b1, 4'h0, cw(1'b1, TBC_SRC_PIN, 4'h0));
            repeat (4) @(posedge clk);
            check(en, 1'b1);
            n = 0;
            repeat (128) @(posedge clk) if (ce === 1'b1) n++;
            check(n, (k == 7) ? 0 : 128 >> k);
            bus(1'b1, 4'h0, 32'h0);
        end
        $display("test divider done");
        for (int i = 0; i < 3; i++)
        begin
            p = (i == 2) ? 4'($random(seed)) : 4'(i * 15);
            bus(1'b1, 4'h0, cw(1'b1, TBC_SRC_PIN, p));
            n = n_ev;
            match(3 * (p + 1));
            repeat (3) @(posedge clk);
            check(n_ev - n, 3);
            bus(1'b1, 4'h0, 32'h0);
        end
        bus(1'b1, 4'h0, cw(1'b1, TBC_SRC_PIN, 4'h3));
        rdx(4'h0, cw(1'b1, TBC_SRC_PIN, 4'h3));
        n = n_ev;
        match(2);
        rdx(4'h8, 32'h20);
        bus(1'b1, 4'h0, cw(1'b0, TBC_SRC_PIN, 4'h3));
        rdx(4'h8, 32'h0);
        bus(1'b1, 4'h0, cw(1'b1, TBC_SRC_PIN, 4'h3));
        match(3);
        repeat (3) @(posedge clk);
        check(n_ev - n, 0);
        match(1);
        repeat (3) @(posedge clk);
        check(n_ev - n, 1);
        bus(1'b1, 4'h0, 32'h0);
        $display("test postscaler done");
        for (int s = 0; s < 8; s++)
        begin
            bus(1'b1, 4'h0, cw(1'b1, 3'(s), 4'h0));
            foreach (PAT[j])
            begin
                {ext, t16, t17} <= PAT[j];
                repeat (5) @(posedge clk);
                check(so, (s == 0) ? PAT[j][2] : (s == 2) ? PAT[j][1] :
                          (s == 3) ? PAT[j][0] : 1'b0);
            end
            bus(1'b1, 4'h0, 32'h0);
        end
        $display("test sync done");
        bus(1'b1, 4'h4, 32'h5);
        bus(1'b1, 4'h0, cw(1'b1, TBC_SRC_TRG16, 4'h7));
        match(2);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check(en, 1'b0);
        rst_n <= 1'b1;
        rdx(4'h0, cw(1'b0, TBC_SRC_PIN, TBC_PS_RESET));
        rdx(4'h4, {29'h0, TBC_DIV_RESET});
        rdx(4'h8, 32'h0);
        $display("test reset done");
        report_and_stop;
    end
endmodule
